// ---- bench/eiu_pin_src.sv ----
// pin-side model of the outside circuitry feeding the interrupt unit
`timescale 1ns/1ps
module eiu_pin_src
   import eiu_pkg::*;
(
   input wire logic aclk,
   output logic ext_pin,
   output logic [CHG_W-1:0] change_input
);
   // idle levels: pin high, change inputs low
   initial begin
      ext_pin = 1'b1;
      change_input = '0;
   end
   // level held long
   // move the pin just after an edge, then hold it three clocks
   task automatic set_ext(input logic v);
      @(posedge aclk);
      ext_pin <= v;
      repeat (3) @(posedge aclk);
   endtask
   // wider than clock
   // toggle one change input and keep the new level
   task automatic flip(input int i);
      @(posedge aclk);
      change_input <= change_input ^ (CHG_W'(1) << i);
      repeat (3) @(posedge aclk);
   endtask
endmodule

// ---- bench/eiu_top_tb.sv ----
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module eiu_top_tb;
   import eiu_pkg::*;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, ext_pin;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [CHG_W-1:0] change_input;
   logic [15:0] irq_vector;
   eiu_src_s irq_ack, irq_req;
   int failures, samples_checked, cycles;
   eiu_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .ext_pin(ext_pin), .change_input(change_input),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector));
   eiu_pin_src src (.aclk(aclk), .ext_pin(ext_pin), .change_input(change_input));
   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // hang guard, far above the expected few hundred cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         finish_test();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // write one register; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // read one register and compare data and response
   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, {24'h0, ed});
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // watch one request line for eight clocks, then the vector
   task automatic want_req(input int b, input logic e, input logic [15:0] v);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge aclk);
         if (irq_req[b] === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen}, {31'h0, e});
      if (e) chk({16'h0, irq_vector}, {16'h0, v});
   endtask
   // one-cycle service-entry pulse from the core
   task automatic ack(input eiu_src_s s);
      @(posedge aclk);
      irq_ack <= s;
      @(posedge aclk);
      irq_ack <= '0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // reset values, writable bits, unmapped place
   task automatic t_regs();
      logic [7:0] ad [5];
      logic [7:0] rb [5];
      ad = '{ADDR_MASK0, ADDR_MASK1, ADDR_ENABLE, ADDR_SENSE, ADDR_STATUS};
      rb = '{8'hff, 8'h0f, 8'h31, 8'hc0, 8'h80};
      rd(ADDR_FLAG, 8'h00, RESP_OKAY);
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], 8'h00, RESP_OKAY);
         wr(ad[i], 8'hff, RESP_OKAY);
         rd(ad[i], rb[i], RESP_OKAY);
         wr(ad[i], 8'h00, RESP_OKAY);
      end
      // lane zero strobe off: answered, nothing stored
      wstrb <= 4'h0;
      wr(ADDR_MASK0, 8'hff, RESP_OKAY);
      wstrb <= 4'h1;
      rd(ADDR_MASK0, 8'h00, RESP_OKAY);
      wr(8'h3c, 8'hff, RESP_SLVERR);
      rd(8'h3c, 8'h00, RESP_SLVERR);
   endtask
   // group zero: masked pin, live pin, service clear, group off
   task automatic t_group0();
      wr(ADDR_STATUS, 8'h80, RESP_OKAY);
      wr(ADDR_ENABLE, 8'h10, RESP_OKAY);
      wr(ADDR_MASK0, 8'h01, RESP_OKAY);
      src.flip(1);
      want_req(1, 1'b0, VEC_NONE);
      src.flip(0);
      want_req(1, 1'b1, VEC_G0);
      rd(ADDR_FLAG, 8'h10, RESP_OKAY);
      ack(3'b010);
      rd(ADDR_FLAG, 8'h00, RESP_OKAY);
      want_req(1, 1'b0, VEC_NONE);
      wr(ADDR_ENABLE, 8'h00, RESP_OKAY);
      src.flip(0);
      rd(ADDR_FLAG, 8'h00, RESP_OKAY);
   endtask
   // group one: request, write-zero no effect, write-one clear, set beats clear
   task automatic t_group1();
      wr(ADDR_ENABLE, 8'h20, RESP_OKAY);
      wr(ADDR_MASK1, 8'h01, RESP_OKAY);
      src.flip(8);
      want_req(2, 1'b1, VEC_G1);
      rd(ADDR_FLAG, 8'h20, RESP_OKAY);
      wr(ADDR_FLAG, 8'h00, RESP_OKAY);
      rd(ADDR_FLAG, 8'h20, RESP_OKAY);
      wr(ADDR_FLAG, 8'h20, RESP_OKAY);
      rd(ADDR_FLAG, 8'h00, RESP_OKAY);
      // service pulse lands in the very cycle the new change is seen
      fork
         src.flip(8);
         begin
            @(posedge aclk);
            ack(3'b100);
         end
      join
      rd(ADDR_FLAG, 8'h20, RESP_OKAY);
      wr(ADDR_FLAG, 8'h20, RESP_OKAY);
   endtask
   // dedicated pin: every sense mode, global gate, level mode
   task automatic t_ext();
      logic [7:0] sn [6];
      logic lv [6];
      logic ex [6];
      sn = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'h40, 8'h40};
      lv = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      ex = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      wr(ADDR_ENABLE, 8'h01, RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_SENSE, sn[i], RESP_OKAY);
         src.set_ext(lv[i]);
         want_req(0, ex[i], VEC_EXT);
         rd(ADDR_FLAG, {7'h0, ex[i]}, RESP_OKAY);
         wr(ADDR_FLAG, 8'h01, RESP_OKAY);
      end
      wr(ADDR_STATUS, 8'h00, RESP_OKAY);
      src.set_ext(1'b0);
      want_req(0, 1'b0, VEC_NONE);
      rd(ADDR_FLAG, 8'h01, RESP_OKAY);
      wr(ADDR_FLAG, 8'h01, RESP_OKAY);
      wr(ADDR_SENSE, 8'h00, RESP_OKAY);
      wr(ADDR_STATUS, 8'h80, RESP_OKAY);
      want_req(0, 1'b1, VEC_EXT);
      rd(ADDR_FLAG, 8'h00, RESP_OKAY);
      src.set_ext(1'b1);
      want_req(0, 1'b0, VEC_NONE);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'h1;
      bready = 1'b0;
      rready = 1'b0;
      irq_ack = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_group0();
      t_group1();
      t_ext();
      finish_test();
   end
endmodule

// ---- design/eiu_pkg.sv ----
// constants and types of the external pin interrupt unit
package eiu_pkg;
   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int GROUP0_W = 8;
   localparam int GROUP1_W = 4;
   localparam int CHG_W = GROUP0_W + GROUP1_W;
   // ----------------------------------------
   // register indices and byte addresses
   // ----------------------------------------
   localparam logic [7:0] IDX_MASK0 = 8'h09;
   localparam logic [7:0] IDX_MASK1 = 8'h0a;
   localparam logic [7:0] IDX_FLAG = 8'h0b;
   localparam logic [7:0] IDX_ENABLE = 8'h0c;
   localparam logic [7:0] IDX_SENSE = 8'h0d;
   localparam logic [7:0] IDX_STATUS = 8'h0e;
   localparam logic [7:0] ADDR_MASK0 = {IDX_MASK0[5:0], 2'h0};
   localparam logic [7:0] ADDR_MASK1 = {IDX_MASK1[5:0], 2'h0};
   localparam logic [7:0] ADDR_FLAG = {IDX_FLAG[5:0], 2'h0};
   localparam logic [7:0] ADDR_ENABLE = {IDX_ENABLE[5:0], 2'h0};
   localparam logic [7:0] ADDR_SENSE = {IDX_SENSE[5:0], 2'h0};
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};
   // ----------------------------------------
   // field positions, writable bits, resets
   // ----------------------------------------
   localparam int BIT_G1 = 5;
   localparam int BIT_G0 = 4;
   localparam int BIT_EXT = 0;
   localparam int BIT_SENSE_HI = 7;
   localparam int BIT_SENSE_LO = 6;
   localparam int BIT_GIE = 7;
   localparam logic [7:0] WMASK_ENABLE = 8'h31;
   localparam logic [7:0] WMASK_FLAG = 8'h31;
   localparam logic [7:0] WMASK_MASK1 = 8'h0f;
   localparam logic [7:0] WMASK_SENSE = 8'hc0;
   localparam logic [7:0] WMASK_STATUS = 8'h80;
   localparam logic [7:0] RST_REG = 8'h00;
   // ----------------------------------------
   // vectors and bus answers
   // ----------------------------------------
   localparam logic [15:0] VEC_NONE = 16'h0000;
   localparam logic [15:0] VEC_EXT = 16'h0001;
   localparam logic [15:0] VEC_G0 = 16'h0002;
   localparam logic [15:0] VEC_G1 = 16'h0003;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} eiu_sense_e;
   typedef enum logic {WR_COLLECT, WR_RESP} eiu_wr_e;
   typedef struct packed {
      logic g1;
      logic g0;
      logic ext;
   } eiu_src_s;
endpackage

// ---- design/eiu_top.sv ----
// external pin interrupt unit with axi4-lite register slave
//
// How it works
// - pin request needs global and pin enable
// - sense bits pick low, change, fall, rise
// - pin sampled first, edges from samples
// - pins seen whatever their direction
// - group one change requests its vector
// - group zero change requests its vector
// - mask bit counts only with group enable
// - enable bits 5, 4, 0; reset zero
// - group one flag at bit 5
// - group zero flag at bit 4
// - pin flag at bit 0 on edge
// - flags clear on service or write one
// - level mode keeps pin flag cleared
// - unused bits read as zero
// - group zero mask eight bits, reset zero
// - vectors 0x0001, 0x0002, 0x0003
// - level path needs no history; change paths use the previous sample
// - level mode requests while pin low
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module eiu_top
   import eiu_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic ext_pin,
   input wire logic [CHG_W-1:0] change_input,
   input wire eiu_src_s irq_ack,
   output eiu_src_s irq_req,
   output logic [15:0] irq_vector
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] mask0_q, mask0_d; // group zero mask
   logic [7:0] mask1_q, mask1_d; // group one mask
   logic [7:0] enable_q, enable_d; // enable register
   logic [7:0] flag_q, flag_d; // sticky flags
   logic [7:0] sense_q, sense_d; // sense select
   logic [7:0] status_q, status_d; // global flag word
   logic ext_smp_q, ext_smp_d; // sampled pin
   logic ext_prev_q, ext_prev_d; // previous sample
   logic [CHG_W-1:0] chg_smp_q, chg_smp_d; // sampled change pins
   logic [CHG_W-1:0] chg_prev_q, chg_prev_d; // previous samples
   eiu_src_s req_q, req_d; // request lines
   logic [15:0] vec_q, vec_d; // vector address
   eiu_wr_e wr_st_q, wr_st_d; // write channel state
   logic got_aw_q, got_aw_d; // address taken
   logic got_w_q, got_w_d; // data taken
   logic [ADDR_W-1:0] wr_addr_q, wr_addr_d; // held address
   logic [7:0] wr_data_q, wr_data_d; // held low byte
   logic wr_lane_q, wr_lane_d; // byte lane 0 strobe
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   // ----------------------------------------
   // event terms
   // ----------------------------------------
   eiu_sense_e sense_mode; // decoded sense bits
   eiu_src_s set_s; // hardware set events
   eiu_src_s clr_s; // service or write-one clears
   logic wr_do; // register write commit
   logic wr_hit; // write address mapped
   logic gie; // global interrupt flag
   logic ext_fall, ext_rise; // sampled edges
   logic [GROUP0_W-1:0] diff0; // group zero changes
   logic [GROUP1_W-1:0] diff1; // group one changes
   assign gie = status_q[BIT_GIE];
   assign sense_mode = eiu_sense_e'(sense_q[BIT_SENSE_HI:BIT_SENSE_LO]);
   assign ext_fall = ext_prev_q & ~ext_smp_q;
   assign ext_rise = ~ext_prev_q & ext_smp_q;
   assign diff0 = (chg_smp_q[GROUP0_W-1:0] ^ chg_prev_q[GROUP0_W-1:0]) & mask0_q;
   assign diff1 = (chg_smp_q[CHG_W-1:GROUP0_W] ^ chg_prev_q[CHG_W-1:GROUP0_W])
      & mask1_q[GROUP1_W-1:0];
   // ----------------------------------------
   // pin sampling and event detection
   // ----------------------------------------
   // samples taken every clock, direction of the pad plays no part
   always_comb begin
      ext_smp_d = ext_pin;
      ext_prev_d = ext_smp_q;
      chg_smp_d = change_input;
      chg_prev_d = chg_smp_q;
      set_s = '0;
      case (sense_mode)
         SENSE_ANY: set_s.ext = ext_fall | ext_rise;
         SENSE_FALL: set_s.ext = ext_fall;
         SENSE_RISE: set_s.ext = ext_rise;
         default: set_s.ext = 1'b0; // level mode sets no flag
      endcase
      set_s.g0 = enable_q[BIT_G0] & (|diff0);
      set_s.g1 = enable_q[BIT_G1] & (|diff1);
   end
   // ----------------------------------------
   // flags and register writes
   // ----------------------------------------
   assign wr_do = (wr_st_q == WR_COLLECT) & got_aw_q & got_w_q;
   assign wr_hit = (wr_addr_q == ADDR_MASK0) | (wr_addr_q == ADDR_MASK1)
      | (wr_addr_q == ADDR_FLAG) | (wr_addr_q == ADDR_ENABLE)
      | (wr_addr_q == ADDR_SENSE) | (wr_addr_q == ADDR_STATUS);
   // next register contents from software writes and hardware events
   always_comb begin
      mask0_d = mask0_q;
      mask1_d = mask1_q;
      enable_d = enable_q;
      sense_d = sense_q;
      status_d = status_q;
      clr_s = irq_ack; // cleared on service entry
      if (wr_do && wr_lane_q) begin
         case (wr_addr_q)
            ADDR_MASK0: mask0_d = wr_data_q;
            ADDR_MASK1: mask1_d = wr_data_q & WMASK_MASK1;
            ADDR_ENABLE: enable_d = wr_data_q & WMASK_ENABLE;
            ADDR_SENSE: sense_d = wr_data_q & WMASK_SENSE;
            ADDR_STATUS: status_d = wr_data_q & WMASK_STATUS;
            ADDR_FLAG: begin
               clr_s.g1 = irq_ack.g1 | wr_data_q[BIT_G1];
               clr_s.g0 = irq_ack.g0 | wr_data_q[BIT_G0];
               clr_s.ext = irq_ack.ext | wr_data_q[BIT_EXT];
            end
            default: mask0_d = mask0_q; // unmapped, nothing stored
         endcase
      end
      flag_d = RST_REG;
      flag_d[BIT_G1] = set_s.g1 | (flag_q[BIT_G1] & ~clr_s.g1);
      flag_d[BIT_G0] = set_s.g0 | (flag_q[BIT_G0] & ~clr_s.g0);
      flag_d[BIT_EXT] = set_s.ext | (flag_q[BIT_EXT] & ~clr_s.ext);
      if (sense_mode == SENSE_LOW) begin
         flag_d[BIT_EXT] = 1'b0;
      end
   end
   // ----------------------------------------
   // requests toward the core
   // ----------------------------------------
   always_comb begin
      req_d.ext = gie & enable_q[BIT_EXT]
         & ((sense_mode == SENSE_LOW) ? ~ext_smp_q : flag_q[BIT_EXT]);
      req_d.g0 = gie & enable_q[BIT_G0] & flag_q[BIT_G0];
      req_d.g1 = gie & enable_q[BIT_G1] & flag_q[BIT_G1];
      vec_d = req_d.ext ? VEC_EXT : (req_d.g0 ? VEC_G0 : (req_d.g1 ? VEC_G1 : VEC_NONE));
   end
   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   // address and data taken in either order, answer after both
   always_comb begin
      wr_st_d = wr_st_q;
      got_aw_d = got_aw_q;
      got_w_d = got_w_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      wr_lane_d = wr_lane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      case (wr_st_q)
         WR_COLLECT: begin
            if (awvalid && awready_q) begin
               got_aw_d = 1'b1;
               wr_addr_d = awaddr;
            end
            if (wvalid && wready_q) begin
               got_w_d = 1'b1;
               wr_data_d = wdata[7:0];
               wr_lane_d = wstrb[0];
            end
            if (wr_do) begin
               wr_st_d = WR_RESP;
               got_aw_d = 1'b0;
               got_w_d = 1'b0;
               bvalid_d = 1'b1;
               bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
         end
         WR_RESP: begin
            if (bready) begin
               wr_st_d = WR_COLLECT;
               bvalid_d = 1'b0;
            end
         end
         default: wr_st_d = WR_COLLECT;
      endcase
      awready_d = (wr_st_d == WR_COLLECT) & ~got_aw_d;
      wready_d = (wr_st_d == WR_COLLECT) & ~got_w_d;
   end
   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always_comb begin
      arready_d = ~rvalid_q; // open whenever no answer is pending
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         case (araddr)
            ADDR_MASK0: rdata_d = {24'h000000, mask0_q};
            ADDR_MASK1: rdata_d = {24'h000000, mask1_q};
            ADDR_FLAG: rdata_d = {24'h000000, flag_q};
            ADDR_ENABLE: rdata_d = {24'h000000, enable_q};
            ADDR_SENSE: rdata_d = {24'h000000, sense_q};
            ADDR_STATUS: rdata_d = {24'h000000, status_q};
            default: begin
               rdata_d = 32'h00000000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask0_q <= RST_REG;
         mask1_q <= RST_REG;
         enable_q <= RST_REG;
         flag_q <= RST_REG;
         sense_q <= RST_REG;
         status_q <= RST_REG;
         ext_smp_q <= 1'b1;
         ext_prev_q <= 1'b1;
         chg_smp_q <= '0;
         chg_prev_q <= '0;
         req_q <= '0;
         vec_q <= VEC_NONE;
         wr_st_q <= WR_COLLECT;
         got_aw_q <= 1'b0;
         got_w_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= RST_REG;
         wr_lane_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else begin
         mask0_q <= mask0_d;
         mask1_q <= mask1_d;
         enable_q <= enable_d;
         flag_q <= flag_d;
         sense_q <= sense_d;
         status_q <= status_d;
         ext_smp_q <= ext_smp_d;
         ext_prev_q <= ext_prev_d;
         chg_smp_q <= chg_smp_d;
         chg_prev_q <= chg_prev_d;
         req_q <= req_d;
         vec_q <= vec_d;
         wr_st_q <= wr_st_d;
         got_aw_q <= got_aw_d;
         got_w_q <= got_w_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         wr_lane_q <= wr_lane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign irq_req = req_q;
   assign irq_vector = vec_q;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_fall_seen; (sense_mode == SENSE_FALL) && ext_prev_q && !ext_smp_q; endsequence
   sequence s_level_low;
      (sense_mode == SENSE_LOW) && gie && enable_q[BIT_EXT] && !ext_smp_q;
   endsequence
   property p_req_gated; req_q.ext |-> $past(gie) && $past(enable_q[BIT_EXT]); endproperty
   a_req_gated: assert property (p_req_gated) else $error("pin request without enables");
   property p_fall_flag; s_fall_seen ##1 1'b1 |-> flag_q[BIT_EXT]; endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("falling edge lost");
   property p_level_clear;
      (sense_mode == SENSE_LOW) |=> !flag_q[BIT_EXT] || (sense_mode != SENSE_LOW);
   endproperty
   a_level_clear: assert property (p_level_clear) else $error("pin flag set in level mode");
   property p_level_req; s_level_low |=> req_q.ext && (vec_q == VEC_EXT); endproperty
   a_level_req: assert property (p_level_req) else $error("level request missing");
   property p_g0_change; enable_q[BIT_G0] && (|diff0) |=> flag_q[BIT_G0]; endproperty
   a_g0_change: assert property (p_g0_change) else $error("group zero change lost");
   property p_g1_req; gie && enable_q[BIT_G1] && (|diff1) |=> ##1 req_q.g1; endproperty
   a_g1_req: assert property (p_g1_req) else $error("group one request missing");
   property p_mask_off; !enable_q[BIT_G0] && !flag_q[BIT_G0] |=> !flag_q[BIT_G0]; endproperty
   a_mask_off: assert property (p_mask_off) else $error("group zero set while off");
   property p_set_wins; set_s.g1 && clr_s.g1 |=> flag_q[BIT_G1]; endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");
   property p_w1c; clr_s.g0 && !set_s.g0 |=> !flag_q[BIT_G0]; endproperty
   a_w1c: assert property (p_w1c) else $error("group zero flag not cleared");
   property p_read_flag;
      arvalid && arready_q && (araddr == ADDR_FLAG) |=> rvalid_q && (rdata_q[31:8] == 24'h000000)
         && (rdata_q[3:1] == 3'h0) && (rdata_q[7:6] == 2'h0);
   endproperty
   a_read_flag: assert property (p_read_flag) else $error("flag read wrong");
endmodule
